// >>> rtl/chain_dma_pkg.sv
// Package with descriptor layout, bus carriers and constants for the chaining DMA engine
package chain_dma_pkg;

  // Address and data widths of the system bus
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // Number of descriptor slots and index width
  localparam int DESC_N = 16;
  localparam int IDX_W = 4;
  // Descriptor storage window on the system bus
  localparam logic [ADDR_W-1:0] DESC_BASE = 16'hF000;
  localparam logic [ADDR_W-1:0] DESC_MASK = 16'hFF00;
  // Word index of each descriptor field inside one slot
  localparam logic [1:0] FLD_SRC = 2'h0;
  localparam logic [1:0] FLD_DST = 2'h1;
  localparam logic [1:0] FLD_CNT = 2'h2;
  localparam logic [1:0] FLD_LINK = 2'h3;
  // Link word layout: valid bit and successor index
  localparam int LINK_VALID_BIT = 8;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] ONE_WORD = 16'h0001;

  // One transfer descriptor
  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [15:0] count;
    logic link_valid;
    logic [IDX_W-1:0] link;
  } transfer_descriptor_type;

  // Bus request from the engine (master side)
  typedef struct packed {
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_type;

  // Bus answer to the engine
  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } bus_rsp_type;

endpackage

// >>> rtl/desc_store.sv
// Descriptor storage: a word-addressed register array with one write port and two read ports
`timescale 1ns/1ns
module desc_store
  import chain_dma_pkg::*;
#(
  parameter int N = DESC_N
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Word write port
  input wire logic wr_en,
  input wire logic [IDX_W+1:0] wr_word,
  input wire logic [DATA_W-1:0] wr_data,
  // Word read port
  input wire logic [IDX_W+1:0] rd_word,
  output logic [DATA_W-1:0] rd_data,
  // Whole descriptor read port
  input wire logic [IDX_W-1:0] desc_idx,
  output transfer_descriptor_type desc
);

  logic [DATA_W-1:0] mem_q [4*N];
  logic [DATA_W-1:0] mem_d [4*N];
  logic [DATA_W-1:0] s_w, d_w, c_w, l_w;

  // Next array contents: one word replaced per write
  always_comb begin
    for (int i = 0; i < 4*N; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en) begin
      mem_d[wr_word] = wr_data;
    end
  end

  // Array registers
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4*N; i++) begin
      if (reset) begin
        mem_q[i] <= RESET_WORD;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // Read ports
  assign rd_data = mem_q[rd_word];
  assign s_w = mem_q[{desc_idx, FLD_SRC}];
  assign d_w = mem_q[{desc_idx, FLD_DST}];
  assign c_w = mem_q[{desc_idx, FLD_CNT}];
  assign l_w = mem_q[{desc_idx, FLD_LINK}];
  assign desc = '{src: s_w[ADDR_W-1:0], dst: d_w[ADDR_W-1:0], count: c_w[15:0],
                  link_valid: l_w[LINK_VALID_BIT], link: l_w[IDX_W-1:0]};

endmodule // desc_store

// >>> rtl/chain_dma.sv
// Descriptor-chained DMA engine with bus-mapped descriptor storage
// How it works
// - A descriptor whose link names itself repeats its transfer forever.
// - Two descriptors linking each other alternate, each starting the other.
// - A ring of descriptors, last linking to first, repeats unattended.
// - On completion the successor is fetched fresh from storage and run.
// - A transfer may write a later descriptor's words; the later one uses them.
// - Every descriptor has its own source and destination addresses.
// - Chained descriptors stream header, payload, trailer as one transfer.
// - Packet chains: config copy, data descriptors, then status copy back.
// - Packet sub-chains link into one longer chain without CPU help.
// - Descriptor storage is a window on the system bus, readable and writable.
// - One descriptor may reload another and chain to it, which links back.
`timescale 1ns/1ns
module chain_dma
  import chain_dma_pkg::*;
#(
  parameter int N = DESC_N
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Start a chain at a descriptor
  input wire logic start,
  input wire logic [IDX_W-1:0] start_idx,
  output logic busy,
  output logic chain_done,
  // System bus master port
  output bus_req_type mst,
  input wire bus_rsp_type mst_rsp,
  // System bus slave port onto descriptor storage
  input wire bus_req_type slv,
  output bus_rsp_type slv_rsp
);

  // Descriptor layout in the window: slot i holds four words at DESC_BASE plus 16 times i,
  // namely source, destination, word count and link. The link word carries a valid flag
  // and the successor index; an invalid link ends the chain after the last word.
  // Every word costs one read and one write; addresses step by one word on both sides.

  // Sequencer states: wait for start, copy the stored descriptor, read a word, write it
  typedef enum logic [3:0] {
    IDLE  = 4'b0001,
    LOAD  = 4'b0010,
    READ  = 4'b0100,
    WRITE = 4'b1000
  } state_type;

  state_type state_q, state_d;
  transfer_descriptor_type cur_q, cur_d, fetched;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic done_q, done_d;
  logic [DATA_W-1:0] ack_data_q, ack_data_d;
  logic slv_ack_q, slv_ack_d;
  logic own_hit;
  logic slv_hit;
  logic slv_rd;
  logic wr_en;
  logic own_wr;
  logic own_rd;
  logic [ADDR_W-1:0] own_addr;
  logic [IDX_W+1:0] wr_word;
  logic [IDX_W+1:0] rd_word;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic word_done;
  logic last_word;

  // Address worked on in this state: source while reading, destination while writing.
  // Taken from the descriptor register, not from the master port, so that the window
  // decode and the master request never feed each other.
  assign own_addr = (state_q == WRITE) ? cur_q.dst : cur_q.src;

  // Address decode of the descriptor window
  assign own_hit = (own_addr & DESC_MASK) == DESC_BASE;
  assign slv_hit = slv.req && ((slv.addr & DESC_MASK) == DESC_BASE);
  assign slv_rd = slv_hit && !slv.write;
  assign own_wr = (state_q == WRITE) && own_hit;
  // Own reads wait a cycle while the bus reads the window, as both share one read port
  assign own_rd = (state_q == READ) && own_hit && !slv_rd;

  // Storage write mux, engine first
  // A bus write in the same cycle as an engine write is acknowledged but lost, so
  // software that edits a running chain must not write the window in a cycle in which the chain writes it.
  always_comb begin
    wr_en = own_wr || (slv_hit && slv.write);
    wr_word = own_wr ? own_addr[IDX_W+3:2] : slv.addr[IDX_W+3:2];
    wr_data = own_wr ? data_q : slv.wdata;
    rd_word = slv_rd ? slv.addr[IDX_W+3:2] : own_addr[IDX_W+3:2];
  end

  // Descriptor words: one write port, one word read port, one whole-descriptor port
  desc_store #(.N(N)) u_store (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_en),
    .wr_word(wr_word),
    .wr_data(wr_data),
    .rd_word(rd_word),
    .rd_data(rd_data),
    .desc_idx(idx_q),
    .desc(fetched)
  );

  // Master request from current state
  // Window addresses are served inside, so they never raise the master request
  always_comb begin
    mst = '0;
    if (state_q == READ) begin
      mst.req = !own_hit;
      mst.addr = cur_q.src;
    end else if (state_q == WRITE) begin
      mst.req = !own_hit;
      mst.write = 1'b1;
      mst.addr = cur_q.dst;
      mst.wdata = data_q;
    end
  end

  // One word moved: an internal write lands at once, a bus write on the acknowledge
  assign word_done = own_hit || mst_rsp.ack;
  // The word being written is the last of this descriptor
  assign last_word = cur_q.count == ONE_WORD;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    idx_d = idx_q;
    data_d = data_q;
    done_d = 1'b0;
    unique case (state_q)
      // Start is only looked at here, so it is ignored while busy
      IDLE: begin
        if (start) begin
          idx_d = start_idx;
          state_d = LOAD;
        end
      end
      LOAD: begin
        // A zero count ends the chain here, with no bus traffic
        cur_d = fetched;
        state_d = (fetched.count == '0) ? IDLE : READ;
        done_d = (fetched.count == '0);
      end
      READ: begin
        if (own_rd) begin
          data_d = rd_data;
          state_d = WRITE;
        end else if (!own_hit && mst_rsp.ack) begin
          data_d = mst_rsp.rdata;
          state_d = WRITE;
        end
      end
      WRITE: begin
        if (word_done) begin
          cur_d.src = cur_q.src + ADDR_W'(4);
          cur_d.dst = cur_q.dst + ADDR_W'(4);
          cur_d.count = cur_q.count - ONE_WORD;
          state_d = READ;
          if (last_word) begin
            if (cur_q.link_valid) begin
              idx_d = cur_q.link;
              state_d = LOAD;
            end else begin
              state_d = IDLE;
              done_d = 1'b1;
            end
          end
        end
      end
      default: state_d = IDLE;
    endcase
  end

  // Slave answer one cycle after the request
  // Accesses outside the window get no answer at all; a write answers with zero data.
  // Read data comes from the registered array, so it is settled when the answer stands.
  always_comb begin
    slv_ack_d = slv_hit;
    ack_data_d = (slv_hit && !slv.write) ? rd_data : RESET_WORD;
  end

  // State registers
  // Reset leaves the engine idle with no request and no answer pending
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= IDLE;
      cur_q <= '0;
      idx_q <= '0;
      data_q <= RESET_WORD;
      done_q <= 1'b0;
      slv_ack_q <= 1'b0;
      ack_data_q <= RESET_WORD;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      idx_q <= idx_d;
      data_q <= data_d;
      done_q <= done_d;
      slv_ack_q <= slv_ack_d;
      ack_data_q <= ack_data_d;
    end
  end

  // Status outputs: busy follows the state register, done is a one-cycle registered pulse
  // that stands in the cycle in which busy has just fallen
  assign busy = state_q != IDLE;
  assign chain_done = done_q;
  assign slv_rsp = '{ack: slv_ack_q, rdata: ack_data_q};

endmodule // chain_dma

// >>> verification/chain_dma_asserts.sv
// Port checks for the chaining DMA engine
`timescale 1ns/1ns
module chain_dma_asserts
  import chain_dma_pkg::*;
#(
  parameter int N = DESC_N
) (
  // Clock, reset, control
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [IDX_W-1:0] start_idx,
  input wire logic busy,
  input wire logic chain_done,
  // Bus ports
  input wire bus_req_type mst,
  input wire bus_rsp_type mst_rsp,
  input wire bus_req_type slv,
  input wire bus_rsp_type slv_rsp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Slave access falls in the descriptor window
  logic hit;
  assign hit = (slv.addr & DESC_MASK) == DESC_BASE;
  a_mst_req_holds: assert property (mst.req && !mst_rsp.ack |=> mst.req && $stable(mst))
    else $error("master request changed before ack");
  a_slv_hit_ack: assert property (slv.req && hit |=> slv_rsp.ack)
    else $error("window access not answered");
  a_slv_miss_quiet: assert property (slv.req && !hit |=> !slv_rsp.ack)
    else $error("access outside window answered");
  a_slv_write_zero: assert property (slv.req && slv.write && hit |=> slv_rsp.rdata == '0)
    else $error("write answer carries data");
  a_start_to_busy: assert property (start && !busy |=> busy)
    else $error("start not taken");
  a_done_single: assert property (chain_done |=> !chain_done)
    else $error("done longer than one cycle");
  a_idle_no_req: assert property (!busy |-> !mst.req)
    else $error("bus request while idle");
  a_fall_gives_done: assert property ($fell(busy) |-> ##[0:1] chain_done)
    else $error("chain ended without done");
endmodule // chain_dma_asserts

bind chain_dma chain_dma_asserts #(.N(N)) chk_i (.ref_clk(ref_clk), .reset(reset),
  .start(start), .start_idx(start_idx), .busy(busy), .chain_done(chain_done), .mst(mst),
  .mst_rsp(mst_rsp), .slv(slv), .slv_rsp(slv_rsp));

// >>> verification/bus_mem_model.sv
// Memory and peripheral model on the engine's master port
`timescale 1ns/1ns
module bus_mem_model
  import chain_dma_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Engine master port
  input wire bus_req_type mst,
  output bus_rsp_type mst_rsp
);
  logic [DATA_W-1:0] mem [256];
  int wait_n;
  // Ack after 0..2 idle cycles; read data scrambles outside the ack
  always @(posedge ref_clk) begin
    mst_rsp.ack <= 1'b0;
    mst_rsp.rdata <= ~mst_rsp.rdata;
    if (reset) begin
      mst_rsp.rdata <= '0;
      wait_n <= 0;
    end else if (mst.req && !mst_rsp.ack) begin
      if (wait_n > 0) wait_n <= wait_n - 1;
      else begin
        mst_rsp.ack <= 1'b1;
        wait_n <= $urandom_range(2);
        if (mst.write) mem[mst.addr[9:2]] <= mst.wdata;
        else mst_rsp.rdata <= mem[mst.addr[9:2]];
      end
    end
  end
endmodule // bus_mem_model

// >>> verification/tb.sv
// Testbench for the chaining DMA engine
`timescale 1ns/1ns
module tb;
  import chain_dma_pkg::*;
  logic ref_clk = 0;
  logic reset = 1;
  logic start = 0;
  logic [IDX_W-1:0] start_idx = '0;
  logic busy, chain_done;
  logic [31:0] q, v;
  bus_req_type mst;
  bus_req_type slv = '0;
  bus_rsp_type mst_rsp, slv_rsp;
  int n_fail = 0, n_compared = 0, dones = 0;
  int hits [256];
  chain_dma uut (.ref_clk(ref_clk), .reset(reset), .start(start), .start_idx(start_idx),
    .busy(busy), .chain_done(chain_done), .mst(mst), .mst_rsp(mst_rsp), .slv(slv),
    .slv_rsp(slv_rsp));
  bus_mem_model mem_i (.ref_clk(ref_clk), .reset(reset), .mst(mst), .mst_rsp(mst_rsp));
  // 25 MHz clock
  initial forever #20 ref_clk = ~ref_clk;
  // Count acked writes per word and ended chains
  always @(posedge ref_clk) begin
    if (mst.req && mst.write && mst_rsp.ack) hits[mst.addr[9:2]]++;
    if (chain_done) dones++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] dw(input int i, input int f);
    return DESC_BASE + 16'(i * 16 + f * 4);
  endfunction
  // One slave access; a window hit is answered one cycle later
  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic h);
    @(negedge ref_clk);
    slv = '{1'b1, wr, a, d};
    @(negedge ref_clk);
    slv.req = 1'b0;
    check(slv_rsp.ack, h);
    q = slv_rsp.rdata;
  endtask
  // Write a descriptor and read its link word back
  task automatic set_desc(input int i, input logic [15:0] s, input logic [15:0] d,
      input logic [15:0] n, input int lk);
    logic [31:0] w;
    w = lk < 0 ? 32'h0000_0000 : (32'h0000_0001 << LINK_VALID_BIT) | 32'(lk);
    acc(1, dw(i, 0), {16'h0000, s}, 1);
    acc(1, dw(i, 1), {16'h0000, d}, 1);
    acc(1, dw(i, 2), {16'h0000, n}, 1);
    acc(1, dw(i, 3), w, 1);
    acc(0, dw(i, 3), 32'h0000_0000, 1);
    check(q, w);
  endtask
  // Start a chain, wait a bounded time, check that it has ended when asked, or else that it still runs
  task automatic run(input int i, input int n, input logic ends);
    @(negedge ref_clk);
    start = 1;
    start_idx = IDX_W'(i);
    @(negedge ref_clk);
    start = 0;
    while (busy === 1'b1 && n > 0) begin
      @(negedge ref_clk);
      n--;
    end
    @(negedge ref_clk);
    check(busy, !ends);
    if (busy !== !ends) wrap_up;
  endtask
  initial begin
    void'($urandom(32'h878e_e9c2));
    repeat (10) @(negedge ref_clk);
    reset = 0;
    foreach (mem_i.mem[k]) mem_i.mem[k] = $urandom;
    // Unmapped access, then two segments gathered into one stream
    acc(1, 16'hE000, 32'h0000_0000, 0);
    set_desc(0, 16'h0000, 16'h0200, 16'h0002, 1);
    set_desc(1, 16'h0100, 16'h0208, 16'h0001, -1);
    run(0, 400, 1);
    check(mem_i.mem[8'h80], mem_i.mem[0]);
    check(mem_i.mem[8'h81], mem_i.mem[1]);
    check(mem_i.mem[8'h82], mem_i.mem[8'h40]);
    check(dones, 1);
    // Fetch an address into a later descriptor, which then uses it
    v = {24'h00_0000, 6'($urandom), 2'b00};
    mem_i.mem[8'hC0] = v;
    set_desc(2, 16'h0300, dw(3, 0), 16'h0001, 3);
    set_desc(3, 16'h0380, 16'h0210, 16'h0001, -1);
    run(2, 400, 1);
    check(mem_i.mem[8'h84], mem_i.mem[v[9:2]]);
    acc(0, dw(3, 0), 32'h0000_0000, 1);
    check(q, v);
    // Zero count ends at once with no traffic
    hits = '{default: 0};
    set_desc(4, 16'h0000, 16'h0220, 16'h0000, 4);
    run(4, 50, 1);
    check(dones, 3);
    check(hits[8'h88], 0);
    // Two packets of config copy, two data words and status copy, linked back to back
    for (int p = 0; p < 2; p++) begin
      set_desc(10 + 3 * p, 16'h0040 + 16'(4 * p), 16'h0280 + 16'(16 * p), 16'h0001,
        11 + 3 * p);
      set_desc(11 + 3 * p, 16'h0080 + 16'(8 * p), 16'h0284 + 16'(16 * p), 16'h0002,
        12 + 3 * p);
      set_desc(12 + 3 * p, 16'h0280 + 16'(16 * p), 16'h02C0 + 16'(4 * p), 16'h0001,
        p == 0 ? 13 : -1);
    end
    run(10, 400, 1);
    for (int p = 0; p < 2; p++) begin
      check(mem_i.mem[8'hA0 + 4 * p], mem_i.mem[8'h10 + p]);
      check(mem_i.mem[8'hA1 + 4 * p], mem_i.mem[8'h20 + 2 * p]);
      check(mem_i.mem[8'hA2 + 4 * p], mem_i.mem[8'h21 + 2 * p]);
      check(mem_i.mem[8'hB0 + p], mem_i.mem[8'h10 + p]);
    end
    check(dones, 4);
    // One descriptor reloads another's source and calls it; the other calls back
    v = {24'h00_0000, 6'($urandom), 2'b00};
    mem_i.mem[8'hC4] = v;
    set_desc(7, 16'h0310, dw(6, 0), 16'h0001, 6);
    set_desc(6, 16'h0000, 16'h02E0, 16'h0001, 7);
    hits = '{default: 0};
    run(7, 200, 0);
    check(hits[8'hB8] > 2, 1);
    check(mem_i.mem[8'hB8], mem_i.mem[v[9:2]]);
    acc(0, dw(6, 0), 32'h0000_0000, 1);
    check(q, v);
    reset = 1;
    repeat (2) @(negedge ref_clk);
    reset = 0;
    // Rings of one, two and three descriptors keep running
    for (int k = 1; k <= 3; k++) begin
      for (int i = 0; i < k; i++) begin
        set_desc(8 + i, 16'h0000, 16'h0240 + 16'(4 * i), 16'h0001, 8 + (i + 1) % k);
      end
      hits = '{default: 0};
      run(8, 300, 0);
      for (int i = 0; i < k; i++) check(hits[8'h90 + i] > 2, 1);
      reset = 1;
      repeat (2) @(negedge ref_clk);
      reset = 0;
    end
    wrap_up;
  end
endmodule // tb
